// file: core/dccs_top.sv
// Drive command decode, write/seek checks and status outputs.
// Assumes pin inputs are asynchronous and APB runs on MCLK_IN.
//
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
// Function
// - Cylinder above variant limit raises bad cylinder
// - Offset or bad cylinder blocks seek start
// - Seek while blocked sets device fault
// - Control tag with bus bit 6 clears fault
// - Control tag with bus bit 7 selects head
// - Set-head tag loads head number
// - Three-bit head number picks one of five
// - Nonexistent head reports end of cylinder
// - Several or missing heads raise unsafe error
// - Write in read-only mode flags protect error
// - Write during offset flags error
// - Write while not ready flags error
// - Write during upper threshold flags error
// - Index pulse 4 us from gap clock
// - Combined mark is index OR sector
// - Selected handshake answers controller select
// - Tester gate switches command source to tester
// - Writing status high during write operation
module dccs_top (
    input  wire logic        MCLK_IN,
    input  wire logic        RST_IN,
    input  wire logic        PSEL_IN,
    input  wire logic        PENABLE_IN,
    input  wire logic        PWRITE_IN,
    input  wire logic [7:0]  PADDR_IN,
    input  wire logic [31:0] PWDATA_IN,
    output logic      [31:0] PRDATA_OUT,
    output logic             PREADY_OUT,
    output logic             PSLVERR_OUT,
    input  wire logic [9:0]  CTL_BUS_IN,
    input  wire logic        CTL_CONTROL_TAG_IN,
    input  wire logic        CTL_SET_HEAD_TAG_IN,
    input  wire logic        CTL_SET_CYL_TAG_IN,
    input  wire logic [9:0]  TST_BUS_IN,
    input  wire logic        TST_CONTROL_TAG_IN,
    input  wire logic        TST_SET_HEAD_TAG_IN,
    input  wire logic        TST_SET_CYL_TAG_IN,
    input  wire logic        TESTER_PRESENT_IN,
    input  wire logic        TESTER_GATE_IN,
    input  wire logic        HEAD_OFFSET_IN,
    input  wire logic        DRIVE_READY_IN,
    input  wire logic        UPPER_THRESH_IN,
    input  wire logic        GAP_CLK_IN,
    input  wire logic        SECTOR_IN,
    input  wire logic [4:0]  HEAD_SENSE_IN,
    input  wire logic        DRIVE_PICK_IN,
    input  wire logic        SPIN_UP_REQUEST_IN,
    output logic [4:0]       HEAD_SELECT_OUT,
    output logic             END_OF_CYL_OUT,
    output logic             TRACK_START_PULSE_OUT,
    output logic             COMBINED_MARK_OUT,
    output logic             DRIVE_PICKED_ACK_OUT,
    output logic             WRITING_STATUS_OUT,
    output logic             DEVICE_FAULT_OUT,
    output logic             SEEK_BLOCK_OUT,
    output logic             READY_OUT
);
    // ==========================================================
    // Input synchronisation
    localparam int SW = 40;
    logic [SW-1:0] sy;
    dccs_sync #(.WIDTH(SW)) u_sync (
        .clk_in (MCLK_IN),
        .rst_in (RST_IN),
        .d_in   ({CTL_BUS_IN, CTL_CONTROL_TAG_IN, CTL_SET_HEAD_TAG_IN, CTL_SET_CYL_TAG_IN,
                  TST_BUS_IN, TST_CONTROL_TAG_IN, TST_SET_HEAD_TAG_IN, TST_SET_CYL_TAG_IN,
                  TESTER_PRESENT_IN, TESTER_GATE_IN, HEAD_OFFSET_IN, DRIVE_READY_IN,
                  UPPER_THRESH_IN, GAP_CLK_IN, SECTOR_IN, HEAD_SENSE_IN, DRIVE_PICK_IN,
                  SPIN_UP_REQUEST_IN}),
        .q_out  (sy)
    );
    logic [9:0] tst_bus;
    logic [4:0] head_sense;
    logic       tst_ctl, tst_hd, tst_cyl, present, gate_req, offset, rdy_pin, thresh;
    logic       gap, sector, pick, spin;
    logic [9:0] ctl_bus;
    logic       ctl_ctl, ctl_hd, ctl_cyl;
    assign {ctl_bus, ctl_ctl, ctl_hd, ctl_cyl, tst_bus, tst_ctl, tst_hd, tst_cyl,
            present, gate_req, offset, rdy_pin, thresh, gap, sector, head_sense,
            pick, spin} = sy;

    // Count of asserted heads, used for unsafe and assertion checks
    function automatic logic [2:0] ones5(input logic [4:0] v);
        ones5 = 3'(v[0]) + 3'(v[1]) + 3'(v[2]) + 3'(v[3]) + 3'(v[4]);
    endfunction

    // ==========================================================
    // Command source mux and edge detection
    logic       tester_gate;
    logic [9:0] bus;
    logic       tag_ctl, tag_hd, tag_cyl, active;
    logic       ctl_q_ff, hd_q_ff, cyl_q_ff, gap_q_ff;
    assign tester_gate = present & gate_req;
    assign bus     = tester_gate ? tst_bus : ctl_bus;
    assign tag_ctl = tester_gate ? tst_ctl : ctl_ctl;
    assign tag_hd  = tester_gate ? tst_hd  : ctl_hd;
    assign tag_cyl = tester_gate ? tst_cyl : ctl_cyl;
    // Tester bypasses select so a drive can be exercised offline
    assign active  = pick | tester_gate;

    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            ctl_q_ff <= 1'b0;
            hd_q_ff  <= 1'b0;
            cyl_q_ff <= 1'b0;
            gap_q_ff <= 1'b0;
        end else begin
            ctl_q_ff <= tag_ctl;
            hd_q_ff  <= tag_hd;
            cyl_q_ff <= tag_cyl;
            gap_q_ff <= gap;
        end
    end
    logic ctl_rise, hd_rise, seek_req, write_cmd, write_rise, fault_clr, ready;
    assign ctl_rise   = tag_ctl & ~ctl_q_ff & active;
    assign hd_rise    = tag_hd & ~hd_q_ff & active;
    assign seek_req   = tag_cyl & ~cyl_q_ff & active;
    assign write_cmd  = tag_ctl & bus[dccs_pkg::BIT_WRITE] & active;
    assign write_rise = ctl_rise & bus[dccs_pkg::BIT_WRITE];
    assign fault_clr  = ctl_rise & bus[dccs_pkg::BIT_FLTRST];
    assign ready      = rdy_pin & spin;

    // ==========================================================
    // Control register and cylinder capture
    logic [1:0] ctrl_ff;
    logic [9:0] cyl_ff;
    logic       wr_ctrl;
    assign wr_ctrl = PSEL_IN & PENABLE_IN & PREADY_OUT & PWRITE_IN
                   & (PADDR_IN == dccs_pkg::OFS_CTRL);
    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            ctrl_ff <= dccs_pkg::CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_ff <= PWDATA_IN[1:0];
        end
    end
    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            cyl_ff <= 10'h000;
        end else if (seek_req) begin
            cyl_ff <= bus;
        end
    end
    logic [9:0] cyl_limit;
    logic       cyl_bad;
    assign cyl_limit = ctrl_ff[dccs_pkg::CTRL_LARGE] ? dccs_pkg::CYL_MAX_LARGE
                                                     : dccs_pkg::CYL_MAX_SMALL;
    assign cyl_bad   = seek_req & (bus > cyl_limit);

    // ==========================================================
    // Latched check errors; a new event beats a same-cycle clear
    logic bad_cylinder_err_ff, device_fault_ff, write_protect_err_ff;
    logic write_offset_err_ff, write_not_ready_err_ff, write_threshold_err_ff;
    logic seek_block;
    assign seek_block = offset | bad_cylinder_err_ff;
    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            bad_cylinder_err_ff    <= 1'b0;
            device_fault_ff        <= 1'b0;
            write_protect_err_ff   <= 1'b0;
            write_offset_err_ff    <= 1'b0;
            write_not_ready_err_ff <= 1'b0;
            write_threshold_err_ff <= 1'b0;
        end else begin
            bad_cylinder_err_ff    <= cyl_bad | (bad_cylinder_err_ff & ~fault_clr);
            device_fault_ff        <= (seek_req & seek_block)
                                    | (device_fault_ff & ~fault_clr);
            write_protect_err_ff   <= (write_rise & ctrl_ff[dccs_pkg::CTRL_RDONLY])
                                    | (write_protect_err_ff & ~fault_clr);
            write_offset_err_ff    <= (write_rise & offset)
                                    | (write_offset_err_ff & ~fault_clr);
            write_not_ready_err_ff <= (write_rise & ~ready)
                                    | (write_not_ready_err_ff & ~fault_clr);
            write_threshold_err_ff <= (write_rise & thresh)
                                    | (write_threshold_err_ff & ~fault_clr);
        end
    end

    // ==========================================================
    // Head address and selection
    logic [2:0] head_number_ff;
    logic       head_pick_cmd_ff, heads_unsafe_err_ff, head_valid;
    logic [4:0] nxt_head_sel;
    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            head_number_ff   <= 3'h0;
            head_pick_cmd_ff <= 1'b0;
        end else begin
            if (hd_rise) begin
                head_number_ff <= bus[2:0];
            end
            if (ctl_rise) begin
                head_pick_cmd_ff <= bus[dccs_pkg::BIT_HEAD_PICK];
            end
        end
    end
    assign head_valid = head_number_ff < 3'(dccs_pkg::NUM_HEADS);
    // Weights 1, 2, 4 map to one line for heads 0 to 4, none for 5 to 7
    assign nxt_head_sel = (head_pick_cmd_ff && head_valid)
                        ? 5'(5'h01 << head_number_ff) : 5'h00;
    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            heads_unsafe_err_ff <= 1'b0;
        end else begin
            heads_unsafe_err_ff <= (ones5(head_sense) > 3'h1)
                                 | (head_pick_cmd_ff & head_valid & (head_sense == 5'h00));
        end
    end

    // ==========================================================
    // Index pulse and registered outputs
    logic        track_start_pulse;
    logic [15:0] pulse_len_ff;
    dccs_pulse #(.LEN(dccs_pkg::INDEX_CYC)) u_index (
        .clk_in    (MCLK_IN),
        .rst_in    (RST_IN),
        .trig_in   (gap & ~gap_q_ff),
        .pulse_out (track_start_pulse)
    );
    // Counts high cycles of the pulse; a short repeat could not see 500 of them
    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            pulse_len_ff <= 16'h0000;
        end else if (track_start_pulse) begin
            pulse_len_ff <= pulse_len_ff + 16'h0001;
        end else begin
            pulse_len_ff <= 16'h0000;
        end
    end
    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            HEAD_SELECT_OUT       <= 5'h00;
            END_OF_CYL_OUT        <= 1'b0;
            TRACK_START_PULSE_OUT <= 1'b0;
            COMBINED_MARK_OUT     <= 1'b0;
            DRIVE_PICKED_ACK_OUT  <= 1'b0;
            WRITING_STATUS_OUT    <= 1'b0;
            DEVICE_FAULT_OUT      <= 1'b0;
            SEEK_BLOCK_OUT        <= 1'b0;
            READY_OUT             <= 1'b0;
        end else begin
            HEAD_SELECT_OUT       <= nxt_head_sel;
            END_OF_CYL_OUT        <= ~head_valid;
            TRACK_START_PULSE_OUT <= track_start_pulse;
            COMBINED_MARK_OUT     <= track_start_pulse | sector;
            DRIVE_PICKED_ACK_OUT  <= pick;
            WRITING_STATUS_OUT    <= write_cmd;
            DEVICE_FAULT_OUT      <= device_fault_ff;
            SEEK_BLOCK_OUT        <= seek_block;
            READY_OUT             <= ready;
        end
    end

    // ==========================================================
    // APB slave: data captured in setup, answered in first access
    logic [15:0] status;
    assign status = {1'b0, head_number_ff, 3'h0, END_OF_CYL_OUT, seek_block,
                     heads_unsafe_err_ff, write_threshold_err_ff, write_not_ready_err_ff,
                     write_offset_err_ff, write_protect_err_ff, device_fault_ff,
                     bad_cylinder_err_ff};
    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            PREADY_OUT  <= 1'b0;
            PRDATA_OUT  <= 32'h00000000;
            PSLVERR_OUT <= 1'b0;
        end else begin
            PREADY_OUT  <= PSEL_IN & ~PENABLE_IN;
            PSLVERR_OUT <= 1'b0;
            PRDATA_OUT  <= 32'h00000000;
            if (PSEL_IN && !PENABLE_IN) begin
                case (PADDR_IN)
                    dccs_pkg::OFS_CTRL:   PRDATA_OUT <= {30'h0, ctrl_ff};
                    dccs_pkg::OFS_STATUS: PRDATA_OUT <= {16'h0, status};
                    dccs_pkg::OFS_CYL:    PRDATA_OUT <= {22'h0, cyl_ff};
                    default:              PSLVERR_OUT <= 1'b1;
                endcase
            end
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (RST_IN);

    a_bad_cyl_set: assert property (cyl_bad |=> bad_cylinder_err_ff)
        else $error("bad cylinder not latched");
    a_seek_block_or: assert property (##1 SEEK_BLOCK_OUT == $past(offset | bad_cylinder_err_ff))
        else $error("seek block mismatch");
    a_fault_on_seek: assert property (seek_req && seek_block |=> ##1 DEVICE_FAULT_OUT)
        else $error("device fault missed");
    a_fault_clear: assert property (fault_clr && !(seek_req && seek_block) |=> !device_fault_ff)
        else $error("fault not cleared");
    a_head_load: assert property (hd_rise |=> head_number_ff == $past(bus[2:0]))
        else $error("head number not loaded");
    a_head_onehot: assert property (ones5(HEAD_SELECT_OUT) <= 3'h1)
        else $error("more than one head line");
    a_eoc_head: assert property (##1 END_OF_CYL_OUT == ($past(head_number_ff) > 3'h4))
        else $error("end of cylinder wrong");
    a_unsafe_multi: assert property (ones5(head_sense) > 3'h1 |=> heads_unsafe_err_ff)
        else $error("unsafe not raised");
    a_wprot_set: assert property (write_rise && ctrl_ff[1] |=> write_protect_err_ff)
        else $error("write protect missed");
    a_wofs_set: assert property (write_rise && offset |=> write_offset_err_ff)
        else $error("write offset missed");
    a_wnrdy_set: assert property (write_rise && !ready |=> write_not_ready_err_ff)
        else $error("write not ready missed");
    a_wthr_set: assert property (write_rise && thresh |=> write_threshold_err_ff)
        else $error("write threshold missed");
    a_index_len: assert property ($fell(track_start_pulse)
                                  |-> pulse_len_ff == 16'(dccs_pkg::INDEX_CYC))
        else $error("index pulse length wrong");
    a_mark_or: assert property (##1 COMBINED_MARK_OUT == $past(track_start_pulse | sector))
        else $error("combined mark wrong");
    a_picked_ack: assert property ($rose(pick) |=> DRIVE_PICKED_ACK_OUT)
        else $error("select not acknowledged");
    a_tester_src: assert property (tester_gate |-> bus == tst_bus)
        else $error("tester source not used");
    a_writing_stat: assert property (write_cmd |=> WRITING_STATUS_OUT)
        else $error("writing status missing");
    a_err_hold: assert property (write_offset_err_ff && !fault_clr |=> write_offset_err_ff)
        else $error("error dropped early");

    c_seek_fault: cover property (seek_req && seek_block);
    c_write_prot: cover property (write_rise && ctrl_ff[1]);
    c_index: cover property ($fell(track_start_pulse));
    c_apb_read: cover property (PSEL_IN && PENABLE_IN && PREADY_OUT && !PWRITE_IN);
endmodule

// file: common/dccs_pkg.sv
// Constants shared by the drive command, check and status logic.
// Assumes one 125 MHz clock and an APB slave with 32-bit data.
package dccs_pkg;
    // ==========================================================
    // Register map (byte addresses)
    localparam logic [7:0]  OFS_CTRL      = 8'h00;
    localparam logic [7:0]  OFS_STATUS    = 8'h04;
    localparam logic [7:0]  OFS_CYL       = 8'h08;
    // Control register fields and reset value
    localparam int          CTRL_LARGE    = 0;
    localparam int          CTRL_RDONLY   = 1;
    localparam logic [1:0]  CTRL_RESET    = 2'h0;
    // Status register field positions
    localparam int          ST_BADCYL     = 0;
    localparam int          ST_FAULT      = 1;
    localparam int          ST_WPROT      = 2;
    localparam int          ST_WOFS       = 3;
    localparam int          ST_WNRDY      = 4;
    localparam int          ST_WTHR       = 5;
    localparam int          ST_UNSAFE     = 6;
    localparam int          ST_BLOCK      = 7;
    localparam int          ST_EOC        = 8;
    localparam int          ST_HEAD       = 12;
    // ==========================================================
    // Command bus bits and limits
    localparam int          BUS_W         = 10;
    localparam int          BIT_WRITE     = 1;
    localparam int          BIT_FLTRST    = 6;
    localparam int          BIT_HEAD_PICK = 7;
    localparam logic [9:0]  CYL_MAX_SMALL = 10'd407;
    localparam logic [9:0]  CYL_MAX_LARGE = 10'd815;
    localparam int          NUM_HEADS     = 5;
    // ==========================================================
    // Timing
    localparam int          CLK_PERIOD_NS = 8;
    localparam int          INDEX_NS      = 4000;
    localparam int          INDEX_CYC     = INDEX_NS / CLK_PERIOD_NS;
endpackage

// file: core/dccs_sync.sv
// Two-stage synchroniser for a vector of unrelated level inputs.
// Assumes each bit is a slow level; bits are not coherent as a word.
`timescale 1ns/1ps
module dccs_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    input  wire logic [WIDTH-1:0] d_in,
    output logic      [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] meta_ff;

    // ==========================================================
    // First stage feeds only the second stage
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            meta_ff <= '0;
            q_out   <= '0;
        end else begin
            meta_ff <= d_in;
            q_out   <= meta_ff;
        end
    end
endmodule

// file: core/dccs_pulse.sv
// Fixed-length pulse generator started by a one-cycle trigger.
// Assumes triggers during a running pulse are ignored.
`timescale 1ns/1ps
module dccs_pulse #(
    parameter int LEN = 2
) (
    input  wire logic clk_in,
    input  wire logic rst_in,
    input  wire logic trig_in,
    output logic      pulse_out
);
    logic [15:0] cnt_ff;

    // ==========================================================
    // Down counter; output high while counting
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_ff    <= 16'h0000;
            pulse_out <= 1'b0;
        end else if (trig_in && !pulse_out) begin
            cnt_ff    <= 16'(LEN - 1);
            pulse_out <= 1'b1;
        end else if (cnt_ff != 16'h0000) begin
            cnt_ff    <= cnt_ff - 16'h0001;
        end else begin
            pulse_out <= 1'b0;
        end
    end
endmodule

// file: tb/dccs_far_model.sv
// Far-side model: a controller or a tester driving bus, tags and levels.
// Assumes the drive samples these pins through two flops on its clock.
`timescale 1ns/1ps
module dccs_far_model (
    input  wire logic       clk_in,
    output logic      [9:0] bus_out,
    output logic            ctag_out,
    output logic            htag_out,
    output logic            ytag_out,
    output logic            pick_out,
    output logic            spin_out
);
    // ==========================================================
    // Idle levels from time zero
    initial begin
        bus_out = 10'h000;
        {ctag_out, htag_out, ytag_out} = 3'h0;
        pick_out = 1'h0;
        spin_out = 1'h0;
    end
    // Select (or presence) and sequence levels
    task automatic lines(input logic p, input logic s);
        @(posedge clk_in);
        pick_out <= p;
        spin_out <= s;
    endtask
    // One tagged command; bus settles first, flips once the tag is gone
    task automatic send(input int t, input logic [9:0] b, input int hold);
        @(posedge clk_in);
        bus_out <= b;
        repeat (3) @(posedge clk_in);
        ctag_out <= (t == 0);
        htag_out <= (t == 1);
        ytag_out <= (t == 2);
        repeat (hold) @(posedge clk_in);
        {ctag_out, htag_out, ytag_out} <= 3'h0;
        @(posedge clk_in);
        bus_out <= ~b;
        repeat (3) @(posedge clk_in);
    endtask
endmodule

// file: tb/tb_dccs_top.sv
// Self-checking bench for the drive command, check and status block.
// Assumes far-side models for controller and tester, APB on MCLK_IN.
`timescale 1ns/1ps
module tb_dccs_top;
    // ==========================================================
    // Signals
    logic        mclk, rst, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [9:0]  cbus, tbus, lim;
    logic        cc, ch, cy, cpick, cspin, tc, th, ty, tpres, gate;
    logic        offs, drdy, uth, gap, sect, eoc, track, mark, ack, wrs, fault, blk, rdy;
    logic [4:0]  sense, hsel;
    int          err_count = 0;
    int          n_compared = 0;
    int          cnt;
    // Design and the two far-side parties
    dccs_top u_dccs_top (.MCLK_IN(mclk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(penable),
        .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
        .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .CTL_BUS_IN(cbus),
        .CTL_CONTROL_TAG_IN(cc), .CTL_SET_HEAD_TAG_IN(ch), .CTL_SET_CYL_TAG_IN(cy),
        .TST_BUS_IN(tbus), .TST_CONTROL_TAG_IN(tc), .TST_SET_HEAD_TAG_IN(th),
        .TST_SET_CYL_TAG_IN(ty), .TESTER_PRESENT_IN(tpres), .TESTER_GATE_IN(gate),
        .HEAD_OFFSET_IN(offs), .DRIVE_READY_IN(drdy), .UPPER_THRESH_IN(uth),
        .GAP_CLK_IN(gap), .SECTOR_IN(sect), .HEAD_SENSE_IN(sense), .DRIVE_PICK_IN(cpick),
        .SPIN_UP_REQUEST_IN(cspin), .HEAD_SELECT_OUT(hsel), .END_OF_CYL_OUT(eoc),
        .TRACK_START_PULSE_OUT(track), .COMBINED_MARK_OUT(mark), .DRIVE_PICKED_ACK_OUT(ack),
        .WRITING_STATUS_OUT(wrs), .DEVICE_FAULT_OUT(fault), .SEEK_BLOCK_OUT(blk),
        .READY_OUT(rdy));
    dccs_far_model u_ctl (.clk_in(mclk), .bus_out(cbus), .ctag_out(cc), .htag_out(ch),
        .ytag_out(cy), .pick_out(cpick), .spin_out(cspin));
    dccs_far_model u_tst (.clk_in(mclk), .bus_out(tbus), .ctag_out(tc), .htag_out(th),
        .ytag_out(ty), .pick_out(tpres), .spin_out());
    // ==========================================================
    // Clock, 8 ns period
    initial begin
        mclk = 1'h0;
        forever #4 mclk = ~mclk;
    end
    // Closing report, the single exit of the run
    task automatic give_verdict();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // APB transfer; read data and error sampled at the edge that sees ready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge mclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'h1;
        i = 0;
        do begin
            @(posedge mclk);
            i++;
        end while (pready !== 1'h1 && i < 16);
        rd = pslverr ? 32'hffffffff : prdata;
        psel <= 1'h0;
        penable <= 1'h0;
        if (pready !== 1'h1) begin
            err_count++;
            give_verdict();
        end
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        {rst, psel, penable, pwrite, gate, offs, uth, gap, sect} = 9'h100;
        {paddr, pwdata, drdy, sense} = 46'h0;
        repeat (3) @(posedge mclk);
        rst <= 1'h0;
        @(posedge mclk);
        chk("outs", {hsel, eoc, track, mark, ack, wrs, fault, blk, rdy}, 32'h0);
        apb(1'h0, dccs_pkg::OFS_CTRL, 32'h0);
        chk("ctrl", rd, {30'h0, dccs_pkg::CTRL_RESET});
        apb(1'h1, dccs_pkg::OFS_STATUS, 32'hffffffff);
        apb(1'h0, dccs_pkg::OFS_STATUS, 32'h0);
        chk("status", rd, 32'h0);
        apb(1'h0, 8'h0c, 32'h0);
        chk("unmapped", rd, 32'hffffffff);
        // Select and sequencing
        drdy <= 1'h1;
        u_ctl.lines(1'h1, 1'h0);
        repeat (5) @(posedge mclk);
        chk("ack", {31'h0, ack}, 32'h1);
        chk("rdy", {31'h0, rdy}, 32'h0);
        u_ctl.lines(1'h1, 1'h1);
        repeat (5) @(posedge mclk);
        chk("rdy", {31'h0, rdy}, 32'h1);
        // Cylinder limit of each variant, blocked seek, fault reset
        for (int v = 0; v < 2; v++) begin
            lim = v ? dccs_pkg::CYL_MAX_LARGE : dccs_pkg::CYL_MAX_SMALL;
            apb(1'h1, dccs_pkg::OFS_CTRL, 32'(v));
            u_ctl.send(2, lim, 4);
            apb(1'h0, dccs_pkg::OFS_CYL, 32'h0);
            chk("cyl", rd, {22'h0, lim});
            chk("blk", {31'h0, blk}, 32'h0);
            u_ctl.send(2, lim + 10'h001, 4);
            apb(1'h0, dccs_pkg::OFS_STATUS, 32'h0);
            chk("badcyl", rd & 32'h3, 32'h1);
            chk("blk", {31'h0, blk}, 32'h1);
            u_ctl.send(2, 10'h000, 4);
            chk("fault", {31'h0, fault}, 32'h1);
            u_ctl.send(0, 10'h040, 4);
            chk("fault", {30'h0, fault, blk}, 32'h0);
        end
        // Every head number through the set-head tag
        u_ctl.send(0, 10'h080, 4);
        for (int n = 0; n < 8; n++) begin
            u_ctl.send(1, 10'(n), 4);
            chk("head", {27'h0, hsel}, (n < 5) ? (32'h1 << n) : 32'h0);
            chk("eoc", {31'h0, eoc}, 32'(n > 4));
        end
        u_ctl.send(1, 10'h001, 4);
        for (int s = 0; s < 2; s++) begin
            sense <= s ? 5'h02 : 5'h03;
            repeat (5) @(posedge mclk);
            apb(1'h0, dccs_pkg::OFS_STATUS, 32'h0);
            chk("unsafe", (rd >> dccs_pkg::ST_UNSAFE) & 32'h1, 32'(s == 0));
        end
        // Write attempts under each forbidden condition
        for (int k = 0; k < 4; k++) begin
            apb(1'h1, dccs_pkg::OFS_CTRL, (k == 0) ? 32'h2 : 32'h0);
            offs <= (k == 1);
            drdy <= (k != 2);
            uth <= (k == 3);
            repeat (5) @(posedge mclk);
            chk("blk", {31'h0, blk}, 32'(k == 1));
            fork
                u_ctl.send(0, 10'h002, 8);
                begin
                    repeat (10) @(posedge mclk);
                    chk("wrs", {31'h0, wrs}, 32'h1);
                end
            join
            {offs, drdy, uth} <= 3'h2;
            apb(1'h1, dccs_pkg::OFS_CTRL, 32'h0);
            apb(1'h0, dccs_pkg::OFS_STATUS, 32'h0);
            chk("werr", (rd >> 2) & 32'hf, 32'h1 << k);
            chk("wrs", {31'h0, wrs}, 32'h0);
            u_ctl.send(0, 10'h040, 4);
            apb(1'h0, dccs_pkg::OFS_STATUS, 32'h0);
            chk("werr", rd & 32'h3c, 32'h0);
        end
        // Index pulse length and the combined mark
        gap <= 1'h1;
        cnt = 0;
        for (int c = 0; c < dccs_pkg::INDEX_CYC + 50; c++) begin
            @(posedge mclk);
            cnt += (track === 1'h1);
            if (c == 20) chk("mark", {30'h0, mark, track}, 32'h3);
        end
        chk("index", cnt, dccs_pkg::INDEX_CYC);
        {gap, sect} <= 2'h1;
        repeat (5) @(posedge mclk);
        chk("mark", {30'h0, mark, track}, 32'h2);
        // Tester takes over the command source
        gate <= 1'h1;
        sect <= 1'h0;
        u_tst.lines(1'h1, 1'h0);
        u_ctl.lines(1'h0, 1'h1);
        u_tst.send(0, 10'h080, 4);
        u_tst.send(1, 10'h002, 4);
        chk("head", {26'h0, ack, hsel}, 32'h4);
        give_verdict();
    end
endmodule
